// ---- hdl/sadc_ctrl.sv ----
// digital control of a successive-approximation converter with an AXI4-Lite register slave
// assumes a comparator front end answering within one cycle on the current tap code
//
// Register access over AXI4-Lite was decided locally.
`include "sadc_defs.svh"
module sadc_ctrl #(
	parameter int SAMPLE_CYC = `SADC_SAMPLE_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [19:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [19:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output sadc_pkg::sadc_word_t s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic comp_above,
	output logic [9:0] tap_code,
	output logic sample_en,
	output logic hold_en,
	output logic [2:0] channel_sel,
	output logic [7:0] analog_pin_route,
	output sadc_pkg::sadc_refp_t positive_ref_sel,
	output logic ext_negative_ref_sel,
	output logic converter_clk_en,
	output logic converter_rst,
	output logic conversion_end_irq
);
	import sadc_pkg::*;

	logic [7:0] pce_ff;
	logic [7:0] mode3_ff;
	logic [1:0] ctrl_ff;
	logic [2:0] chan_ff;
	logic [9:0] sar_ff;
	logic [9:0] trial_ff;
	logic [15:0] resw_ff;
	logic [7:0] resb_ff;
	logic stat_ff;
	logic mask_ff;
	sadc_state_t state_ff;
	logic [7:0] cnt_ff;
	logic aw_ff;
	logic w_ff;
	logic [19:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic conv_on;
	logic wr_go;
	logic done_ev;
	logic last_bit;
	logic [9:0] nxt_sar;

	function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
		lane0 = s[0] ? d[7:0] : old;
	endfunction

	// converter clock gate and reset follow bit 5 of the enable register
	assign conv_on = pce_ff[`SADC_PCE_CONV_BIT];
	assign wr_go = aw_ff && w_ff && !s_axi_bvalid;

	// write channel capture, address and data taken in either order
	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awaddr_ff <= 20'h00000;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (wr_go) begin
				w_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_ff && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_ff && !s_axi_wready && !s_axi_bvalid;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			case (awaddr_ff & 20'hFFFFC)
				`SADC_OFF_PCE, `SADC_OFF_MODE3, `SADC_OFF_CTRL, `SADC_OFF_CHAN, `SADC_OFF_RESW,
				`SADC_OFF_RESB, `SADC_OFF_STAT, `SADC_OFF_MASK, `SADC_OFF_SAR: s_axi_bresp <= 2'b00;
				default: s_axi_bresp <= 2'b10;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// enable register: unused bits kept zero whatever software writes
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pce_ff <= `SADC_PCE_RST;
		end else if (wr_go && (awaddr_ff & 20'hFFFFC) == `SADC_OFF_PCE) begin
			pce_ff <= lane0(pce_ff, wdata_ff, wstrb_ff) & `SADC_PCE_USED;
		end
	end

	// control registers locked at reset value while the converter clock is off
	always_ff @(posedge core_clk) begin
		if (rst || !conv_on) begin
			mode3_ff <= 8'h00;
			chan_ff <= 3'h0;
			mask_ff <= 1'b0;
		end else if (wr_go) begin
			case (awaddr_ff & 20'hFFFFC)
				`SADC_OFF_MODE3: mode3_ff <= lane0(mode3_ff, wdata_ff, wstrb_ff) & `SADC_M3_USED;
				`SADC_OFF_CHAN: if (wstrb_ff[0]) chan_ff <= wdata_ff[2:0];
				`SADC_OFF_MASK: if (wstrb_ff[0]) mask_ff <= wdata_ff[0];
				default: ;
			endcase
		end
	end

	// start bit clears itself after a one-shot conversion
	always_ff @(posedge core_clk) begin
		if (rst || !conv_on) begin
			ctrl_ff <= 2'b00;
		end else if (wr_go && wstrb_ff[0] && (awaddr_ff & 20'hFFFFC) == `SADC_OFF_CTRL) begin
			ctrl_ff <= wdata_ff[1:0];
		end else if (done_ev && !ctrl_ff[`SADC_CTRL_CONT_BIT]) begin
			ctrl_ff[`SADC_CTRL_START_BIT] <= 1'b0;
		end
	end

	assign last_bit = mode3_ff[`SADC_M3_TYP_BIT] ? trial_ff[2] : trial_ff[0];

	always_comb begin
		nxt_sar = sar_ff;
		// keep or drop the trial bit, then try the next lower one
		if (!comp_above) begin
			nxt_sar = sar_ff & ~trial_ff;
		end
		if (!last_bit) begin
			nxt_sar = nxt_sar | (trial_ff >> 1);
		end
	end

	assign done_ev = (state_ff == SADC_CONVERT) && last_bit;

	always_ff @(posedge core_clk) begin
		if (rst || !conv_on) begin
			state_ff <= SADC_IDLE;
			sar_ff <= 10'h000;
			trial_ff <= 10'h000;
			cnt_ff <= 8'h00;
		end else begin
			case (state_ff)
				SADC_IDLE: begin
					if (ctrl_ff[`SADC_CTRL_START_BIT]) begin
						state_ff <= SADC_SAMPLE;
						cnt_ff <= 8'h00;
					end
				end
				SADC_SAMPLE: begin
					cnt_ff <= cnt_ff + 8'h01;
					if (cnt_ff == 8'(SAMPLE_CYC - 1)) begin
						state_ff <= SADC_CONVERT;
						sar_ff <= 10'h200;
						trial_ff <= 10'h200;
					end
				end
				SADC_CONVERT: begin
					sar_ff <= nxt_sar;
					trial_ff <= trial_ff >> 1;
					if (last_bit) begin
						state_ff <= SADC_DONE;
					end
				end
				SADC_DONE: begin
					state_ff <= ctrl_ff[`SADC_CTRL_START_BIT] ? SADC_SAMPLE : SADC_IDLE;
					cnt_ff <= 8'h00;
				end
				default: state_ff <= SADC_IDLE;
			endcase
		end
	end

	// results written once per completed conversion and held until the next, cleared while the converter is off
	always_ff @(posedge core_clk) begin
		if (rst || !conv_on) begin
			resw_ff <= 16'h0000;
			resb_ff <= 8'h00;
		end else if (done_ev) begin
			resw_ff <= {nxt_sar, 6'h00};
			resb_ff <= nxt_sar[9:2];
		end
	end

	// sticky end flag, write one clears, a new end wins over the clear
	always_ff @(posedge core_clk) begin
		if (rst || !conv_on) begin
			stat_ff <= 1'b0;
		end else if (done_ev) begin
			stat_ff <= 1'b1;
		end else if (wr_go && wstrb_ff[0] && wdata_ff[0] && (awaddr_ff & 20'hFFFFC) == `SADC_OFF_STAT) begin
			stat_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			conversion_end_irq <= 1'b0;
		end else begin
			conversion_end_irq <= stat_ff && mask_ff;
		end
	end

	// analog front-end controls, one register per concern

	// tap code: half scale on entry to conversion, then the next trial pattern
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tap_code <= 10'h000;
		end else begin
			tap_code <= (state_ff == SADC_SAMPLE && cnt_ff == 8'(SAMPLE_CYC - 1)) ? 10'h200 :
				(state_ff == SADC_CONVERT ? nxt_sar : sar_ff);
		end
	end

	// tracking runs from the start request until the last sample cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sample_en <= 1'b0;
		end else begin
			sample_en <= state_ff == SADC_IDLE ? ctrl_ff[`SADC_CTRL_START_BIT] :
				(state_ff == SADC_SAMPLE && cnt_ff != 8'(SAMPLE_CYC - 1));
		end
	end

	// hold covers every comparison so the input cannot move under the sequencer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			hold_en <= 1'b0;
		end else begin
			hold_en <= (state_ff == SADC_SAMPLE && cnt_ff == 8'(SAMPLE_CYC - 1)) ||
				(state_ff == SADC_CONVERT && !last_bit);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			channel_sel <= 3'h0;
		end else begin
			channel_sel <= chan_ff;
		end
	end

	// unselected pins stay free for port use
	always_ff @(posedge core_clk) begin
		if (rst) begin
			analog_pin_route <= 8'h00;
		end else begin
			analog_pin_route <= (state_ff != SADC_IDLE || ctrl_ff[0]) ? 8'(1 << chan_ff) : 8'h00;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			positive_ref_sel <= SADC_REFP_SUPPLY;
		end else begin
			case ({mode3_ff[`SADC_M3_REFP1_BIT], mode3_ff[`SADC_M3_REFP0_BIT]})
				2'b01: positive_ref_sel <= SADC_REFP_EXT;
				2'b10: positive_ref_sel <= SADC_REFP_INT;
				default: positive_ref_sel <= SADC_REFP_SUPPLY;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ext_negative_ref_sel <= 1'b0;
		end else begin
			ext_negative_ref_sel <= mode3_ff[`SADC_M3_REFM_BIT];
		end
	end

	// converter clock gate follows the enable bit
	always_ff @(posedge core_clk) begin
		if (rst) begin
			converter_clk_en <= 1'b0;
		end else begin
			converter_clk_en <= conv_on;
		end
	end

	// converter reset is the inverse of the gate and high during system reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			converter_rst <= 1'b1;
		end else begin
			converter_rst <= !conv_on;
		end
	end

	// read channel, one read at a time
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr & 20'hFFFFC)
					`SADC_OFF_PCE: s_axi_rdata <= {24'h000000, pce_ff};
					`SADC_OFF_MODE3: s_axi_rdata <= {24'h000000, mode3_ff};
					`SADC_OFF_CTRL: s_axi_rdata <= {30'h00000000, ctrl_ff};
					`SADC_OFF_CHAN: s_axi_rdata <= {29'h00000000, chan_ff};
					`SADC_OFF_RESW: s_axi_rdata <= {16'h0000, resw_ff};
					`SADC_OFF_RESB: s_axi_rdata <= {24'h000000, resb_ff};
					`SADC_OFF_STAT: s_axi_rdata <= {31'h00000000, stat_ff};
					`SADC_OFF_MASK: s_axi_rdata <= {31'h00000000, mask_ff};
					`SADC_OFF_SAR: s_axi_rdata <= {22'h000000, sar_ff};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // sadc_ctrl

// ---- hdl/sadc_defs.svh ----
// register offsets, field positions, reset values and timing counts of the converter control block
// assumes inclusion by bare name from the control module and the bench
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH
`define SADC_OFF_PCE 20'hF00F0
`define SADC_OFF_MODE3 20'hF0100
`define SADC_OFF_CTRL 20'hF0104
`define SADC_OFF_CHAN 20'hF0108
`define SADC_OFF_RESW 20'hF010C
`define SADC_OFF_RESB 20'hF0110
`define SADC_OFF_STAT 20'hF0114
`define SADC_OFF_MASK 20'hF0118
`define SADC_OFF_SAR 20'hF011C
`define SADC_PCE_RST 8'h00
`define SADC_PCE_USED 8'hA5
`define SADC_PCE_CONV_BIT 5
`define SADC_M3_REFM_BIT 5
`define SADC_M3_REFP1_BIT 7
`define SADC_M3_REFP0_BIT 6
`define SADC_M3_TYP_BIT 0
`define SADC_M3_USED 8'hE1
`define SADC_CTRL_START_BIT 0
`define SADC_CTRL_CONT_BIT 1
`define SADC_SAMPLE_NS 64
`define SADC_CLK_NS 8
`define SADC_SAMPLE_CYC ((`SADC_SAMPLE_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`endif

// ---- hdl/sadc_pkg.sv ----
// types shared by the converter control block
// assumes nothing beyond the defines header
package sadc_pkg;
	typedef enum logic [1:0] {
		SADC_IDLE = 2'b00,
		SADC_SAMPLE = 2'b01,
		SADC_CONVERT = 2'b11,
		SADC_DONE = 2'b10
	} sadc_state_t;
	typedef enum logic [1:0] {
		SADC_REFP_SUPPLY = 2'b00,
		SADC_REFP_EXT = 2'b01,
		SADC_REFP_INT = 2'b10
	} sadc_refp_t;
	typedef logic [31:0] sadc_word_t;
endpackage

// ---- verification/sadc_ctrl_checker.sv ----
// port checker for the converter control block
// assumes binding onto sadc_ctrl, one clock domain
module sadc_ctrl_checker (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic converter_rst,
	input wire logic converter_clk_en,
	input wire logic conversion_end_irq,
	input wire logic sample_en,
	input wire logic hold_en,
	input wire logic [9:0] tap_code,
	input wire logic [2:0] channel_sel,
	input wire logic [7:0] analog_pin_route
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	property p_gate;
		converter_clk_en != converter_rst;
	endproperty
	a_gate: assert property (p_gate) else $error("gate and reset disagree");
	property p_held;
		converter_rst[*3] |-> !sample_en && !hold_en && !conversion_end_irq;
	endproperty
	a_held: assert property (p_held) else $error("converter active while held");
	property p_rel;
		$fell(rst) |-> converter_rst && !converter_clk_en;
	endproperty
	a_rel: assert property (p_rel) else $error("enable not cleared by reset");
	property p_first;
		$rose(hold_en) |-> tap_code == 10'h200;
	endproperty
	a_first: assert property (p_first) else $error("first tap not half");
	property p_second;
		$rose(hold_en) |=> tap_code[8] && tap_code[7:0] == 8'h00;
	endproperty
	a_second: assert property (p_second) else $error("second trial wrong");
	property p_len;
		$rose(hold_en) |-> hold_en[*8] ##[0:4] !hold_en;
	endproperty
	a_len: assert property (p_len) else $error("conversion length wrong");
	property p_excl;
		hold_en |-> !sample_en;
	endproperty
	a_excl: assert property (p_excl) else $error("sampling during hold");
	property p_route;
		analog_pin_route != 8'h00 |-> analog_pin_route == 8'h01 << channel_sel;
	endproperty
	a_route: assert property (p_route) else $error("pin route not selected channel");
	c_irq: cover property ($rose(conversion_end_irq));
	c_hold: cover property ($rose(hold_en));
	c_off: cover property ($rose(converter_rst));
endmodule // sadc_ctrl_checker

bind sadc_ctrl sadc_ctrl_checker i_chk (.core_clk, .rst, .converter_rst, .converter_clk_en,
	.conversion_end_irq, .sample_en, .hold_en, .tap_code, .channel_sel, .analog_pin_route);

// ---- verification/sadc_front.sv ----
// comparator and sample-and-hold front end model
// assumes input and tap share one ten-bit scale
module sadc_front (
	input wire logic core_clk,
	input wire logic [9:0] vin,
	input wire logic sample_en,
	input wire logic [9:0] tap_code,
	output logic comp_above
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] held_ff;
	// input frozen once tracking ends
	always_ff @(posedge core_clk) begin
		if (sample_en) begin
			held_ff <= vin;
		end
	end
	assign comp_above = held_ff >= tap_code;
endmodule // sadc_front

// ---- verification/sadc_ctrl_tb.sv ----
// self-checking bench for the converter control block
// assumes the front end model and the bound checker
`include "sadc_defs.svh"
module sadc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sadc_pkg::*;
	typedef struct {logic [9:0] vin; logic [7:0] m3; logic [15:0] w; logic [7:0] b; sadc_refp_t rp; logic rm;} sadc_row_t;
	logic core_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, comp_above;
	logic sample_en, hold_en, ext_negative_ref_sel, converter_clk_en, converter_rst, conversion_end_irq;
	logic [19:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, rd;
	sadc_word_t s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [9:0] tap_code, vin;
	logic [2:0] channel_sel;
	logic [7:0] analog_pin_route;
	sadc_refp_t positive_ref_sel;
	int n_mismatch, n_compared, k;
	sadc_row_t rows [6] = '{
		'{10'h200, 8'h40, 16'h8000, 8'h80, SADC_REFP_EXT, 1'b0},
		'{10'h1FF, 8'h60, 16'h7FC0, 8'h7F, SADC_REFP_EXT, 1'b1},
		'{10'h3FF, 8'h80, 16'hFFC0, 8'hFF, SADC_REFP_INT, 1'b0},
		'{10'h000, 8'h00, 16'h0000, 8'h00, SADC_REFP_SUPPLY, 1'b0},
		'{10'h2AB, 8'h41, 16'hAA00, 8'hAA, SADC_REFP_EXT, 1'b0},
		'{10'h155, 8'h21, 16'h5500, 8'h55, SADC_REFP_SUPPLY, 1'b1}};
	sadc_ctrl #(.SAMPLE_CYC(2)) i_dut (.*);
	sadc_front i_front (.core_clk, .vin, .sample_en, .tap_code, .comp_above);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdr(input logic [19:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic report_and_stop;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		#50000;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, vin} = '0;
		s_axi_wstrb = 4'hF;
		rst = 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rdr(`SADC_OFF_PCE);
		chk("enable", rd, 32'h0);
		wr(`SADC_OFF_PCE, 8'h20);
		wr(`SADC_OFF_MASK, 8'h01);
		foreach (rows[i]) begin
			vin <= rows[i].vin;
			wr(`SADC_OFF_MODE3, rows[i].m3);
			wr(`SADC_OFF_CHAN, 8'(i));
			@(posedge core_clk);
			chk("refp", positive_ref_sel, rows[i].rp);
			chk("refm", ext_negative_ref_sel, rows[i].rm);
			chk("chan", channel_sel, i);
			wr(`SADC_OFF_CTRL, 8'h01);
			// input moves during hold; result must not follow it
			for (k = 0; k < 200 && conversion_end_irq !== 1'b1; k++) begin
				@(posedge core_clk);
				if (hold_en) vin <= ~vin;
			end
			chk("irq", conversion_end_irq, 1);
			rdr(`SADC_OFF_RESW);
			chk("wide", rd, rows[i].w);
			rdr(`SADC_OFF_RESB);
			chk("byte", rd, rows[i].b);
			wr(`SADC_OFF_STAT, 8'h01);
			repeat (2) @(posedge core_clk);
			chk("irq", conversion_end_irq, 0);
		end
		wr(`SADC_OFF_MASK, 8'h00);
		wr(`SADC_OFF_CTRL, 8'h01);
		repeat (30) @(posedge core_clk);
		chk("masked", conversion_end_irq, 0);
		rdr(`SADC_OFF_STAT);
		chk("status", rd, 32'h1);
		wr(`SADC_OFF_MASK, 8'h01);
		repeat (2) @(posedge core_clk);
		chk("unmasked", conversion_end_irq, 1);
		wr(`SADC_OFF_STAT, 8'h01);
		rdr(20'hF0200);
		chk("unmapped", {rd[29:0], rsp}, 32'h2);
		wr(20'hF0200, 8'h01);
		chk("unmapped_w", rsp, 2'b10);
		wr(`SADC_OFF_RESW, 8'hFF);
		rdr(`SADC_OFF_RESW);
		chk("ro", rd, 32'h5500);
		wr(`SADC_OFF_PCE, 8'h00);
		repeat (2) @(posedge core_clk);
		chk("conv_rst", {converter_rst, converter_clk_en}, 2'b10);
		wr(`SADC_OFF_MODE3, 8'h40);
		rdr(`SADC_OFF_MODE3);
		chk("mode_off", rd, 32'h0);
		rdr(`SADC_OFF_RESW);
		chk("res_off", rd, 32'h0);
		wr(`SADC_OFF_PCE, 8'h24);
		rdr(`SADC_OFF_PCE);
		chk("enable", rd, 32'h24);
		wr(`SADC_OFF_CTRL, 8'h01);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rdr(`SADC_OFF_PCE);
		chk("enable", rd, 32'h0);
		chk("conv_rst", converter_rst, 1);
		report_and_stop();
	end
endmodule // sadc_ctrl_tb
